/* File: verilog/lp2_pins_pkg.sv */
package lp2_pins_pkg;
  // pin widths
  localparam int CA_W = 10;
  localparam int DQ_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  // sampling of pins that arrive from outside mclk
  localparam int SYNC_STAGES = 3;
  // write beat buffer: data plus one store enable per lane
  localparam int FIFO_DEPTH = 16;
  localparam int BEAT_W = DQ_W + LANES;
  // reset values
  localparam logic RST_CKE = 1'b0;
  localparam logic RST_PWR_DOWN = 1'b1;
  localparam logic RST_CS_N = 1'b1;
  localparam logic RST_DQS = 1'b0;
  localparam logic [CA_W-1:0] RST_CA = 10'h000;
  localparam logic [DQ_W-1:0] RST_DQ = 32'h0000_0000;
  // timing
  localparam int MCLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  // command capture phases
  typedef enum logic [0:0] {
    CAP_RISE,
    CAP_FALL
  } cap_phase_t;
endpackage

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] stable_o
);
  import lp2_pins_pkg::*;

  logic [W-1:0] meta_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] stable_ff;

  // meta_ff feeds s2_ff only
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      meta_ff <= pin_i;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit moves only once two stages agree, filtering single-cycle glitches
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_ff <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          stable_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign stable_o = stable_ff;
endmodule
`default_nettype wire

/* File: verilog/beat_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module beat_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr_ff];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/lp2_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module lp2_pins (
  input wire logic mclk_i,
  input wire logic rstn_i,
  // link pins to and from the controller
  input wire logic ck_t_i,
  input wire logic ck_c_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic [lp2_pins_pkg::CA_W-1:0] ca_i,
  input wire logic [lp2_pins_pkg::DQ_W-1:0] dq_i,
  output logic [lp2_pins_pkg::DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [lp2_pins_pkg::LANES-1:0] dqs_t_i,
  input wire logic [lp2_pins_pkg::LANES-1:0] dqs_c_i,
  output logic [lp2_pins_pkg::LANES-1:0] dqs_t_o,
  output logic [lp2_pins_pkg::LANES-1:0] dqs_c_o,
  output logic dqs_oe_o,
  input wire logic [lp2_pins_pkg::LANES-1:0] dm_i,
  // core side: clocking and power
  output logic clk_en_o,
  output logic pwr_down_o,
  // core side: decoded command word
  output logic cmd_valid_o,
  output logic cmd_cke_o,
  output logic cmd_cs_n_o,
  output logic [lp2_pins_pkg::CA_W-1:0] cmd_ca_rise_o,
  output logic [lp2_pins_pkg::CA_W-1:0] cmd_ca_fall_o,
  // core side: write beats
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [lp2_pins_pkg::DQ_W-1:0] wr_data_o,
  output logic [lp2_pins_pkg::LANES-1:0] wr_be_o,
  output logic wr_overrun_o,
  input wire logic wr_overrun_clr_i,
  // core side: read beats
  input wire logic rd_en_i,
  input wire logic rd_beat_i,
  input wire logic [lp2_pins_pkg::DQ_W-1:0] rd_data_i
);
  import lp2_pins_pkg::*;

  logic rst_meta_ff;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // pin sampling
  logic ck_t_s;
  logic ck_c_s;
  logic cke_s;
  logic cs_n_s;
  logic [CA_W-1:0] ca_s;
  logic [LANES-1:0] dqs_t_s;
  logic [LANES-1:0] dqs_c_s;
  logic [DQ_W-1:0] dq_s;
  logic [LANES-1:0] dm_s;

  // strobe, data and mask share one sampler so their latency matches
  pin_sync #(.W(CA_W + 4)) u_sync_cmd (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .pin_i({ck_t_i, ck_c_i, cke_i, cs_n_i, ca_i}),
    .stable_o({ck_t_s, ck_c_s, cke_s, cs_n_s, ca_s})
  );

  pin_sync #(.W(DQ_W + 3 * LANES)) u_sync_dat (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .pin_i({dqs_t_i, dqs_c_i, dq_i, dm_i}),
    .stable_o({dqs_t_s, dqs_c_s, dq_s, dm_s})
  );

  // link clock edges
  logic ck_prev_ff;
  logic ck_rise;
  logic ck_fall;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev_ff <= 1'b0;
    end else begin
      ck_prev_ff <= ck_t_s;
    end
  end

  // the complement must agree, so a lone glitch on one leg is no edge
  assign ck_rise = ck_t_s & ~ck_prev_ff & ~ck_c_s;
  assign ck_fall = ~ck_t_s & ck_prev_ff & ck_c_s;

  // clock enable and power state
  logic cke_ff;
  logic pwr_down_ff;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cke_ff <= RST_CKE;
    end else if (ck_rise) begin
      cke_ff <= cke_s;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_down_ff <= RST_PWR_DOWN;
    end else if (ck_rise && cke_ff && !cke_s) begin
      pwr_down_ff <= 1'b1;
    end else if (ck_rise && !cke_ff && cke_s) begin
      pwr_down_ff <= 1'b0;
    end
  end

  assign clk_en_o = cke_ff;
  assign pwr_down_o = pwr_down_ff;

  // command capture over one link clock
  cap_phase_t phase_ff;
  logic rise_take;
  logic cmd_valid_ff;
  logic cmd_cke_ff;
  logic cmd_cs_n_ff;
  logic [CA_W-1:0] ca_rise_ff;
  logic [CA_W-1:0] ca_fall_ff;

  // receivers stay live for the rise that brings CKE back high
  assign rise_take = ck_rise & (cke_ff | cke_s);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= CAP_RISE;
      cmd_valid_ff <= 1'b0;
      cmd_cke_ff <= RST_CKE;
      cmd_cs_n_ff <= RST_CS_N;
      ca_rise_ff <= RST_CA;
      ca_fall_ff <= RST_CA;
    end else begin
      cmd_valid_ff <= 1'b0;
      unique case (phase_ff)
        CAP_RISE: begin
          if (rise_take) begin
            cmd_cke_ff <= cke_s;
            cmd_cs_n_ff <= cs_n_s;
            ca_rise_ff <= ca_s;
            phase_ff <= CAP_FALL;
          end
        end
        CAP_FALL: begin
          if (ck_fall) begin
            ca_fall_ff <= ca_s;
            cmd_valid_ff <= 1'b1;
            phase_ff <= CAP_RISE;
          end
        end
      endcase
    end
  end

  assign cmd_valid_o = cmd_valid_ff;
  assign cmd_cke_o = cmd_cke_ff;
  assign cmd_cs_n_o = cmd_cs_n_ff;
  assign cmd_ca_rise_o = ca_rise_ff;
  assign cmd_ca_fall_o = ca_fall_ff;

  // read drive
  logic dq_oe_ff;
  logic [DQ_W-1:0] dq_out_ff;
  logic dqs_out_ff;
  logic rd_step;

  assign rd_step = rd_beat_i & rd_en_i & cke_ff;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dq_oe_ff <= 1'b0;
    end else begin
      dq_oe_ff <= rd_en_i & cke_ff;
    end
  end

  // strobe toggles in the same cycle as data, giving edge alignment
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dq_out_ff <= RST_DQ;
      dqs_out_ff <= RST_DQS;
    end else if (rd_step) begin
      dq_out_ff <= rd_data_i;
      dqs_out_ff <= ~dqs_out_ff;
    end else if (!rd_en_i) begin
      dqs_out_ff <= RST_DQS;
    end
  end

  assign dq_o = dq_out_ff;
  assign dq_oe_o = dq_oe_ff;
  assign dqs_t_o = {LANES{dqs_out_ff}};
  assign dqs_c_o = {LANES{~dqs_out_ff}};
  assign dqs_oe_o = dq_oe_ff;

  // write capture, one strobe per byte lane
  logic [LANES-1:0] dqs_prev_ff;
  logic [LANES-1:0] lane_edge;
  logic [LANES-1:0] in_be;
  logic in_valid;
  logic in_ready;
  logic overrun_ff;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dqs_prev_ff <= '0;
    end else begin
      dqs_prev_ff <= dqs_t_s;
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    // both strobe edges count; inputs are ignored while we drive
    assign lane_edge[l] = (dqs_t_s[l] != dqs_prev_ff[l]) & (dqs_t_s[l] != dqs_c_s[l])
                          & cke_ff & ~dq_oe_ff;
    assign in_be[l] = lane_edge[l] & ~dm_s[l];
  end

  assign in_valid = |lane_edge;

  // a full buffer drops the beat; the controller cannot be stalled
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      overrun_ff <= 1'b0;
    end else if (in_valid && !in_ready) begin
      overrun_ff <= 1'b1;
    end else if (wr_overrun_clr_i) begin
      overrun_ff <= 1'b0;
    end
  end

  assign wr_overrun_o = overrun_ff;

  beat_fifo #(.WIDTH(BEAT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .in_valid_i(in_valid),
    .in_ready_o(in_ready),
    .in_data_i({in_be, dq_s}),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o({wr_be_o, wr_data_o})
  );

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  property p_cke_gate;
    !cke_ff |=> !dq_oe_o && !dqs_oe_o;
  endproperty
  a_cke_gate: assert property (p_cke_gate) else $error("drivers on while cke low");

  property p_pwr_edge;
    $changed(pwr_down_ff) |-> $past(ck_rise) && ($past(cke_s) != $past(cke_ff));
  endproperty
  a_pwr_edge: assert property (p_pwr_edge) else $error("power state moved without cke edge");

  property p_cke_sample;
    ck_rise |=> clk_en_o == $past(cke_s);
  endproperty
  a_cke_sample: assert property (p_cke_sample) else $error("cke not taken on rising clock");

  property p_cs_sample;
    (phase_ff == CAP_RISE) && rise_take |=> cmd_cs_n_o == $past(cs_n_s) && cmd_ca_rise_o == $past(ca_s);
  endproperty
  a_cs_sample: assert property (p_cs_sample) else $error("rise half of command lost");

  property p_ca_fall;
    (phase_ff == CAP_FALL) && ck_fall |=> cmd_valid_o && cmd_ca_fall_o == $past(ca_s);
  endproperty
  a_ca_fall: assert property (p_ca_fall) else $error("fall half of command lost");

  property p_cmd_pair;
    cmd_valid_o |-> $past(phase_ff) == CAP_FALL && phase_ff == CAP_RISE;
  endproperty
  a_cmd_pair: assert property (p_cmd_pair) else $error("command without both halves");

  property p_rd_beat;
    rd_step |=> dq_o == $past(rd_data_i) && dqs_t_o[0] != $past(dqs_t_o[0]) && dqs_c_o == ~dqs_t_o;
  endproperty
  a_rd_beat: assert property (p_rd_beat) else $error("read beat without strobe");

  property p_rd_align;
    dq_oe_o && $changed(dq_o) |-> $changed(dqs_t_o);
  endproperty
  a_rd_align: assert property (p_rd_align) else $error("read data moved off strobe edge");

  property p_mask;
    in_valid && dm_s[0] |-> !in_be[0];
  endproperty
  a_mask: assert property (p_mask) else $error("masked lane 0 stored");

  property p_lane3;
    lane_edge[3] && !dm_s[3] |-> in_be[3] && in_valid;
  endproperty
  a_lane3: assert property (p_lane3) else $error("lane 3 beat dropped");

  property p_lane_own;
    in_be[2] |-> lane_edge[2];
  endproperty
  a_lane_own: assert property (p_lane_own) else $error("lane 2 stored without its strobe");

  property p_no_fight;
    dq_oe_o |-> !in_valid;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("write taken while driving");

  c_cmd: cover property (cmd_valid_o && !cmd_cs_n_o);
  c_write: cover property (in_valid && in_ready && in_be == 4'hf);
  c_read: cover property (rd_step ##1 rd_step);
  c_pwr: cover property ($fell(pwr_down_ff));
endmodule
`default_nettype wire

/* File: sim/lp2_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lp2_ctrl_model (
  input wire logic mclk_i,
  output logic ck_t_o,
  output logic ck_c_o,
  output logic cke_o,
  output logic cs_n_o,
  output logic [lp2_pins_pkg::CA_W-1:0] ca_o,
  output logic [lp2_pins_pkg::DQ_W-1:0] dq_o,
  output logic [lp2_pins_pkg::LANES-1:0] dqs_t_o,
  output logic [lp2_pins_pkg::LANES-1:0] dqs_c_o,
  output logic [lp2_pins_pkg::LANES-1:0] dm_o
);
  import lp2_pins_pkg::*;
  assign ck_c_o = ~ck_t_o;
  assign dqs_c_o = ~dqs_t_o;
  initial begin
    ck_t_o = 1'b0;
    cke_o = 1'b0;
    cs_n_o = 1'b1;
    ca_o = '0;
    dq_o = '0;
    dqs_t_o = '0;
    dm_o = '0;
  end
  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // link clock stands still between frames
  task automatic send_cmd(input logic cke, input logic cs_n, input logic [CA_W-1:0] ca_r, input logic [CA_W-1:0] ca_f);
    cke_o = cke;
    cs_n_o = cs_n;
    ca_o = ca_r;
    step(4);
    ck_t_o = 1'b1;
    step(2);
    ca_o = ca_f;
    step(2);
    ck_t_o = 1'b0;
    step(4);
    // hold time over: inverted so a stale value cannot pass
    ca_o = ~ca_f;
    cs_n_o = 1'b1;
  endtask
  // strobe edge centred in a 8-cycle data eye
  task automatic wr_beat(input logic [3:0] lanes, input logic [DQ_W-1:0] d, input logic [3:0] m);
    dq_o = d;
    dm_o = m;
    step(4);
    dqs_t_o = dqs_t_o ^ lanes;
    step(4);
    dq_o = ~d;
    dm_o = ~m;
    step(2);
  endtask
endmodule
`default_nettype wire

/* File: sim/test_lp2_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module test_lp2_pins;
  import lp2_pins_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic rd_beat_i = 1'b0;
  logic [31:0] rd_data_i = '0;
  logic wr_ready_i = 1'b0;
  logic wr_overrun_clr_i = 1'b0;
  logic ck_t, ck_c, cke, cs_n, dq_oe, dqs_oe, clk_en, pwr_down, cmd_valid, cmd_cke, cmd_cs_n, wr_valid, wr_overrun;
  logic [9:0] ca, ca_rise, ca_fall;
  logic [31:0] dq_m, dq_d, dq_w, wr_data;
  logic [3:0] dqs_t_m, dqs_c_m, dqs_t_d, dqs_c_d, dqs_t_w, dqs_c_w, dm, wr_be;
  int bad_count = 0;
  int samples_checked = 0;
  always #50 mclk_i = ~mclk_i;
  // wire level of the shared pins, as seen at the DUT inputs only
  assign dq_w = dq_oe ? dq_d : dq_m;
  assign dqs_t_w = dqs_oe ? dqs_t_d : dqs_t_m;
  assign dqs_c_w = dqs_oe ? dqs_c_d : dqs_c_m;
  lp2_ctrl_model i_ctrl (.mclk_i(mclk_i), .ck_t_o(ck_t), .ck_c_o(ck_c), .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca),
    .dq_o(dq_m), .dqs_t_o(dqs_t_m), .dqs_c_o(dqs_c_m), .dm_o(dm));
  lp2_pins i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ck_t_i(ck_t), .ck_c_i(ck_c), .cke_i(cke), .cs_n_i(cs_n),
    .ca_i(ca), .dq_i(dq_w), .dq_o(dq_d), .dq_oe_o(dq_oe), .dqs_t_i(dqs_t_w), .dqs_c_i(dqs_c_w),
    .dqs_t_o(dqs_t_d), .dqs_c_o(dqs_c_d), .dqs_oe_o(dqs_oe), .dm_i(dm), .clk_en_o(clk_en),
    .pwr_down_o(pwr_down), .cmd_valid_o(cmd_valid), .cmd_cke_o(cmd_cke), .cmd_cs_n_o(cmd_cs_n),
    .cmd_ca_rise_o(ca_rise), .cmd_ca_fall_o(ca_fall), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready_i),
    .wr_data_o(wr_data), .wr_be_o(wr_be), .wr_overrun_o(wr_overrun), .wr_overrun_clr_i(wr_overrun_clr_i),
    .rd_en_i(rd_en_i), .rd_beat_i(rd_beat_i), .rd_data_i(rd_data_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a taken command must give exactly one valid cycle
  task automatic t_cmd(input logic k, input logic s, input logic [9:0] r, input logic [9:0] f, input int n_exp);
    int n;
    n = 0;
    fork
      i_ctrl.send_cmd(k, s, r, f);
      repeat (22) begin
        @(negedge mclk_i);
        if (cmd_valid === 1'b1) n++;
      end
    join
    chk(n, n_exp, "cmd pulses");
    // a refused rise must leave the power state alone as well
    chk({clk_en, pwr_down}, {k, ~k}, "power state");
    if (n_exp > 0) begin
      chk({cmd_cke, cmd_cs_n}, {k, s}, "cmd cke cs");
      chk(ca_rise, r, "ca rise");
      chk(ca_fall, f, "ca fall");
    end
  endtask
  task automatic pop(input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    chk(wr_valid, 1'b1, "wr valid");
    chk(wr_be, be, "byte enables");
    chk(wr_data & m, d & m, "wr data");
    wr_ready_i = 1'b1;
    @(negedge mclk_i);
    wr_ready_i = 1'b0;
  endtask
  task automatic t_write;
    logic [3:0] msk [3];
    msk = '{4'h4, 4'h1, 4'h8};
    for (int l = 0; l < 4; l++) begin
      i_ctrl.wr_beat(4'(1 << l), 32'h11223344 << l, ~4'(1 << l));
      pop(32'h11223344 << l, 4'(1 << l));
    end
    // masks on falling, rising, falling strobe edges
    foreach (msk[i]) begin
      i_ctrl.wr_beat(4'hf, 32'hc0de0000 + i, msk[i]);
      pop(32'hc0de0000 + i, ~msk[i]);
    end
    chk(wr_valid, 1'b0, "fifo empty");
  endtask
  task automatic t_fifo;
    for (int i = 0; i < 18; i++) begin
      i_ctrl.wr_beat(4'h1, 32'(i), 4'h0);
      if (i == 15 || i == 16) chk(wr_overrun, i == 16, "overrun");
    end
    wr_overrun_clr_i = 1'b1;
    @(negedge mclk_i);
    wr_overrun_clr_i = 1'b0;
    @(negedge mclk_i);
    chk(wr_overrun, 1'b0, "overrun cleared");
    for (int i = 0; i < 16; i++) pop(32'(i), 4'h1);
    chk(wr_valid, 1'b0, "drained");
  endtask
  task automatic t_read(input logic on);
    logic [3:0] prev;
    rd_en_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk({dq_oe, dqs_oe}, {on, on}, "drive enable");
    prev = dqs_t_d;
    for (int i = 0; i < 3; i++) begin
      rd_beat_i = 1'b1;
      rd_data_i = 32'ha5a50f0f ^ (32'h01010101 << i);
      @(negedge mclk_i);
      if (on) begin
        chk(dq_d, rd_data_i, "read data");
        chk({dqs_t_d, dqs_c_d}, {~prev, prev}, "read strobe");
        prev = ~prev;
      end
    end
    rd_beat_i = 1'b0;
    rd_en_i = 1'b0;
    repeat (8) @(negedge mclk_i);
    chk({dq_oe, dqs_t_d, wr_valid}, 6'h00, "read end");
  endtask
  initial begin
    repeat (8) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (10) @(negedge mclk_i);
    // powered down, cke low, chip deselected, strobe complement high, nothing driven
    chk({pwr_down, clk_en, cmd_cs_n, dqs_c_d, dq_oe, wr_valid}, 9'h17c, "reset state");
    t_cmd(1'b0, 1'b0, 10'h155, 10'h2aa, 0);
    t_cmd(1'b1, 1'b0, 10'h3a5, 10'h15a, 1);
    t_cmd(1'b1, 1'b1, 10'h000, 10'h3ff, 1);
    t_write;
    t_fifo;
    t_read(1'b1);
    t_cmd(1'b0, 1'b0, 10'h0f0, 10'h30f, 1);
    t_read(1'b0);
    i_ctrl.wr_beat(4'h1, 32'h5, 4'h0);
    chk(wr_valid, 1'b0, "write while gated");
    wrap_up;
  end
  initial begin
    #1000000;
    bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
